// [logic/tdec_pkg.sv]
// constants shared by the transmit data encoder and its register file
// assumes a 100 MHz system clock and a classic wishbone register bus
package tdec_pkg;

  localparam int CLK_HZ = 100_000_000;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CODING = 8'h4A;
  localparam logic [7:0] IDX_MOD    = 8'h4B;
  localparam logic [7:0] IDX_DATA   = 8'h60;
  localparam logic [7:0] IDX_CTRL   = 8'h61;

  localparam logic [7:0] CODING_RST = 8'h00;
  localparam logic [7:0] MOD_RST    = 8'h00;

  // field positions
  localparam int CODE_LSB   = 4;
  localparam int SCF_BIT    = 3;
  localparam int BR_LSB     = 0;
  localparam int FSTEP_BIT  = 7;
  localparam int MILLER_BIT = 6;
  localparam int PTYPE_LSB  = 4;
  localparam int INV_BIT    = 3;
  localparam int ENV_LSB    = 0;
  localparam int START_BIT  = 0;

  // data codes
  localparam logic [3:0] CODE_NONE    = 4'h0;
  localparam logic [3:0] CODE_COLLIDE = 4'h1;
  localparam logic [3:0] CODE_RZ1     = 4'h4;
  localparam logic [3:0] CODE_RZ4     = 4'h7;
  localparam logic [3:0] CODE_1OF4    = 4'h8;
  localparam logic [3:0] CODE_256     = 4'h9;
  localparam logic [3:0] CODE_256Z    = 4'hA;
  localparam logic [3:0] CODE_256L    = 4'hB;
  localparam logic [3:0] CODE_PIE     = 4'hC;

  // envelope shapes
  localparam logic [2:0] ENV_DIRECT = 3'h0;
  localparam logic [2:0] ENV_MANCH  = 3'h1;
  localparam logic [2:0] ENV_MANSC  = 3'h2;
  localparam logic [2:0] ENV_BPSK   = 3'h3;
  localparam logic [2:0] ENV_RZ2ND  = 3'h4;
  localparam logic [2:0] ENV_RZ1ST  = 3'h5;

  // bit stream and subcarrier rates
  localparam int BR_26K_HZ  = 26_000;
  localparam int BR_53K_HZ  = 53_000;
  localparam int BR_106K_HZ = 106_000;
  localparam int BR_212K_HZ = 212_000;
  localparam int BR_424K_HZ = 424_000;
  localparam int BR_848K_HZ = 848_000;
  localparam int SC_424K_HZ = 424_000;
  localparam int SC_848K_HZ = 848_000;
  // cycles per quarter bit and per subcarrier half period
  localparam int Q_26K  = CLK_HZ / (4 * BR_26K_HZ);
  localparam int Q_53K  = CLK_HZ / (4 * BR_53K_HZ);
  localparam int Q_106K = CLK_HZ / (4 * BR_106K_HZ);
  localparam int Q_212K = CLK_HZ / (4 * BR_212K_HZ);
  localparam int Q_424K = CLK_HZ / (4 * BR_424K_HZ);
  localparam int Q_848K = CLK_HZ / (4 * BR_848K_HZ);
  localparam int SCH_424K = CLK_HZ / (2 * SC_424K_HZ);
  localparam int SCH_848K = CLK_HZ / (2 * SC_848K_HZ);

  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_GAP  = 2'b10
  } tdec_state_type;

endpackage

// [logic/tdec_encoder.sv]
// transmit data encoder: byte fifo, pseudo bit coding, pulse and envelope shaping
// assumes a single 100 MHz clock, synchronous reset and a classic wishbone master
//
// Operation
// [R1] code field in upper nibble of coding register; 0 plain, 1 collider stream
// [R2] codes 4 to 7 give return-to-zero, pulse at slot one to four
// [R3] code 8 gives one-out-of-four pulse position coding
// [R4] code 9 gives one-out-of-256 coding over byte values 0 to 255
// [R5] code 10: one-out-of-256, byte zero sends no modulation
// [R6] code 11: one-out-of-256, byte zero pulses in the last slot
// [R7] code 12 gives pulse-interval coding; 2, 3, 13 to 15 reserved
// [R8] subcarrier select bit 3: 0 gives 424 kHz, 1 gives 848 kHz
// [R9] subcarrier select only matters for envelopes that use a subcarrier
// [R10] bit rate field codes 2 to 7 give 26 to 848 kHz
// [R11] per-byte framing bit sends every byte in its own frame
// [R12] per-byte framing restarts itself automatically between bytes
// [R13] without per-byte framing one trigger sends all bytes in one frame
// [R14] miller bit applies modified miller; software must set pulse type 1
// [R15] pulse type: none, at bit start, second half, third quarter
// [R16] invert bit inverts the data envelope
// [R17] envelope: direct, manchester, manchester with subcarrier, bpsk; 6, 7 reserved
// [R18] envelope 4 pulses second half, envelope 5 pulses first half
// [R19] software must not program reserved codes
//
// The Wishbone register port was decided locally.
`timescale 1ns/100ps

module tdec_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       wr_valid_i,
  output logic                            wr_ready_o,
  input  wire logic [WIDTH-1:0]           wr_data_i,
  output logic                            rd_valid_o,
  input  wire logic                       rd_ready_i,
  output logic      [WIDTH-1:0]           rd_data_o,
  output logic      [$clog2(DEPTH):0]     count_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr_reg;
  logic [AW:0]      wptr_next;
  logic [AW:0]      rptr_reg;
  logic [AW:0]      rptr_next;
  logic             push;
  logic             pop;

  assign count_o    = wptr_reg - rptr_reg;
  assign wr_ready_o = (count_o != (AW+1)'(DEPTH));
  assign rd_valid_o = (wptr_reg != rptr_reg);
  assign rd_data_o  = mem[rptr_reg[AW-1:0]];
  assign push       = wr_valid_i & wr_ready_o;
  assign pop        = rd_ready_i & rd_valid_o;

  always_comb begin
    wptr_next = push ? wptr_reg + 1'b1 : wptr_reg;
    rptr_next = pop ? rptr_reg + 1'b1 : rptr_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
    end
    if (push) begin
      mem[wptr_reg[AW-1:0]] <= wr_data_i;
    end
  end
endmodule // tdec_fifo

module tdec_encoder (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             tx_envelope_o,
  output logic             tx_active_o
);
  import tdec_pkg::*;

  // pseudo bit of slot s for byte b under data code c
  function automatic logic pseudo_bit(input logic [3:0] c, input logic [7:0] b,
                                      input logic [8:0] s);
    logic       r;
    logic [8:0] pos;
    logic [8:0] len;
    logic [7:0] sh;
    r   = 1'b0;
    pos = '0;
    sh  = b >> {s[3:2], 1'b0};
    if (c >= CODE_RZ1 && c <= CODE_RZ4) begin
      r = b[s[4:2]] & (s[1:0] == c[1:0]); // [R2]
    end else if (c == CODE_1OF4) begin
      r = (s[1:0] == sh[1:0]); // [R3]
    end else if (c == CODE_256) begin
      r = (s[7:0] == b); // [R4]
    end else if (c == CODE_256Z) begin
      r = (b != 8'h00) && (s[7:0] == b); // [R5]
    end else if (c == CODE_256L) begin
      r = (s[7:0] == b - 8'h01); // [R6]
    end else if (c == CODE_PIE) begin
      // a zero is high-low, a one is high-high-low
      for (int i = 0; i < 8; i++) begin
        len = b[i] ? 9'h003 : 9'h002;
        if (s >= pos && s < 9'(pos + len)) begin
          r = (s != 9'(pos + len - 9'h001)); // [R7]
        end
        pos = 9'(pos + len);
      end
    end else begin
      // plain, collider and reserved codes pass the byte lsb first
      r = b[s[2:0]]; // [R1]
    end
    return r;
  endfunction

  // index of the last slot of one byte
  function automatic logic [8:0] last_slot(input logic [3:0] c, input logic [7:0] b);
    logic [8:0] n;
    n = 9'h007;
    if (c >= CODE_RZ1 && c <= CODE_RZ4) begin
      n = 9'h01F;
    end else if (c == CODE_1OF4) begin
      n = 9'h00F;
    end else if (c == CODE_256 || c == CODE_256Z || c == CODE_256L) begin
      n = 9'h0FF;
    end else if (c == CODE_PIE) begin
      n = 9'h00F;
      for (int i = 0; i < 8; i++) begin
        n = 9'(n + {8'h00, b[i]});
      end
    end
    return n;
  endfunction

  function automatic logic [11:0] quarter_len(input logic [2:0] br);
    logic [11:0] q;
    unique case (br)
      3'h3:    q = 12'(Q_53K);
      3'h4:    q = 12'(Q_106K);
      3'h5:    q = 12'(Q_212K);
      3'h6:    q = 12'(Q_424K);
      3'h7:    q = 12'(Q_848K);
      default: q = 12'(Q_26K); // reserved 0 and 1 run at the slowest rate
    endcase
    return q;
  endfunction

  // register file and bus
  logic [7:0]  coding_reg;
  logic [7:0]  coding_next;
  logic [7:0]  mod_reg;
  logic [7:0]  mod_next;
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic [7:0]  idx;
  logic        req;
  logic        commit;
  logic        start;
  logic [31:0] rd_mux;

  logic        fifo_wr_ready;
  logic        fifo_rd_valid;
  logic        fifo_rd_ready;
  logic [7:0]  fifo_rd_data;
  logic [4:0]  fifo_count;

  tdec_state_type state_reg;
  tdec_state_type state_next;

  assign idx    = wb_adr_i[9:2];
  assign req    = wb_cyc_i & wb_stb_i;
  assign commit = ack_reg & req & wb_we_i & wb_sel_i[0];
  assign start  = commit & (idx == IDX_CTRL) & wb_dat_i[START_BIT];

  always_comb begin
    unique case (idx)
      IDX_CODING: rd_mux = {24'h000000, coding_reg};
      IDX_MOD:    rd_mux = {24'h000000, mod_reg};
      IDX_CTRL:   rd_mux = {23'h000000, fifo_count, tx_active_o, ~fifo_wr_ready,
                            ~fifo_rd_valid, (state_reg != ST_IDLE)};
      default:    rd_mux = 32'h00000000;
    endcase
  end

  always_comb begin
    // data writes wait for room so the source is throttled
    ack_next    = req & ~ack_reg & ~(wb_we_i & (idx == IDX_DATA) & ~fifo_wr_ready);
    dat_next    = ack_next ? rd_mux : 32'h00000000;
    coding_next = (commit && idx == IDX_CODING) ? wb_dat_i[7:0] : coding_reg;
    mod_next    = (commit && idx == IDX_MOD) ? wb_dat_i[7:0] : mod_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg    <= 1'b0;
      dat_reg    <= 32'h00000000;
      coding_reg <= CODING_RST;
      mod_reg    <= MOD_RST;
    end else begin
      ack_reg    <= ack_next;
      dat_reg    <= dat_next;
      coding_reg <= coding_next;
      mod_reg    <= mod_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  tdec_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .wr_valid_i (commit & (idx == IDX_DATA)),
    .wr_ready_o (fifo_wr_ready),
    .wr_data_i  (wb_dat_i[7:0]),
    .rd_valid_o (fifo_rd_valid),
    .rd_ready_i (fifo_rd_ready),
    .rd_data_o  (fifo_rd_data),
    .count_o    (fifo_count)
  );

  // configuration fields
  logic [3:0]  code;
  logic        scf;
  logic [2:0]  br;
  logic        fstep;
  logic        miller;
  logic [1:0]  ptype;
  logic        inv;
  logic [2:0]  env;
  assign code   = coding_reg[CODE_LSB +: 4];
  assign scf    = coding_reg[SCF_BIT];
  assign br     = coding_reg[BR_LSB +: 3];
  assign fstep  = mod_reg[FSTEP_BIT];
  assign miller = mod_reg[MILLER_BIT];
  assign ptype  = mod_reg[PTYPE_LSB +: 2];
  assign inv    = mod_reg[INV_BIT];
  assign env    = mod_reg[ENV_LSB +: 3];

  // encoder state
  logic [7:0]  byte_reg;
  logic [7:0]  byte_next;
  logic [8:0]  slot_reg;
  logic [8:0]  slot_next;
  logic [1:0]  quarter_reg;
  logic [1:0]  quarter_next;
  logic [11:0] tick_cnt_reg;
  logic [11:0] tick_cnt_next;
  logic        prev_reg;
  logic        prev_next;
  logic [7:0]  sc_cnt_reg;
  logic [7:0]  sc_cnt_next;
  logic        sc_reg;
  logic        sc_next;
  logic        env_reg;
  logic        env_next;
  logic        tick;
  logic        byte_end;
  logic        pb;
  logic        mod_level;
  logic        sc_on;
  logic [7:0]  sc_half_m1;
  logic        shaped;

  assign tick       = (tick_cnt_reg == 12'(quarter_len(br) - 12'h001)); // [R10]
  assign byte_end   = (state_reg == ST_SEND) && tick && (quarter_reg == 2'h3)
                      && (slot_reg == last_slot(code, byte_reg));
  assign pb         = pseudo_bit(code, byte_reg, slot_reg);
  // subcarrier only runs for envelopes that carry one
  assign sc_on      = (state_reg == ST_SEND) && (env == ENV_MANSC || env == ENV_BPSK); // [R9]
  assign sc_half_m1 = scf ? 8'(SCH_848K - 1) : 8'(SCH_424K - 1); // [R8]

  always_comb begin
    if (miller) begin
      // a zero after a one carries no pulse
      mod_level = pb ? (quarter_reg == 2'h2) : (~prev_reg & (quarter_reg == 2'h0)); // [R14]
    end else begin
      unique case (ptype)
        2'h1:    mod_level = pb & (quarter_reg == 2'h0); // [R15]
        2'h2:    mod_level = pb & quarter_reg[1]; // [R15]
        2'h3:    mod_level = pb & (quarter_reg == 2'h2); // [R15]
        default: mod_level = pb;
      endcase
    end
    unique case (env)
      ENV_MANCH: shaped = quarter_reg[1] ? ~mod_level : mod_level; // [R17]
      ENV_MANSC: shaped = sc_reg & (quarter_reg[1] ? ~mod_level : mod_level); // [R17]
      ENV_BPSK:  shaped = sc_reg ^ mod_level; // [R17]
      ENV_RZ2ND: shaped = mod_level & quarter_reg[1]; // [R18]
      ENV_RZ1ST: shaped = mod_level & ~quarter_reg[1]; // [R18]
      default:   shaped = mod_level;
    endcase
  end

  always_comb begin
    state_next    = state_reg;
    byte_next     = byte_reg;
    slot_next     = slot_reg;
    quarter_next  = quarter_reg;
    tick_cnt_next = tick ? 12'h000 : tick_cnt_reg + 12'h001;
    prev_next     = prev_reg;
    fifo_rd_ready = 1'b0;
    env_next      = (state_reg == ST_SEND) ? (shaped ^ inv) : 1'b0; // [R16]
    sc_cnt_next   = 8'h00;
    sc_next       = 1'b0;
    if (sc_on) begin
      sc_cnt_next = (sc_cnt_reg == sc_half_m1) ? 8'h00 : sc_cnt_reg + 8'h01;
      sc_next     = (sc_cnt_reg == sc_half_m1) ? ~sc_reg : sc_reg;
    end
    unique case (state_reg)
      ST_IDLE: begin
        tick_cnt_next = 12'h000;
        if (start && fifo_rd_valid) begin
          fifo_rd_ready = 1'b1;
          byte_next     = fifo_rd_data;
          slot_next     = '0;
          quarter_next  = 2'h0;
          prev_next     = 1'b0;
          state_next    = ST_SEND;
        end
      end
      ST_SEND: begin
        if (tick) begin
          quarter_next = quarter_reg + 2'h1;
          if (quarter_reg == 2'h3) begin
            prev_next = pb;
            slot_next = slot_reg + 9'h001;
          end
        end
        if (byte_end) begin
          slot_next = '0;
          if (fstep) begin
            state_next = ST_GAP; // [R11]
          end else if (fifo_rd_valid) begin
            fifo_rd_ready = 1'b1; // [R13]
            byte_next     = fifo_rd_data;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_GAP: begin
        // one bit period of silence, then the next frame starts on its own
        if (tick) begin
          quarter_next = quarter_reg + 2'h1;
          if (quarter_reg == 2'h3) begin
            prev_next = 1'b0;
            if (fifo_rd_valid) begin
              fifo_rd_ready = 1'b1; // [R12]
              byte_next     = fifo_rd_data;
              state_next    = ST_SEND;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg    <= ST_IDLE;
      byte_reg     <= 8'h00;
      slot_reg     <= '0;
      quarter_reg  <= 2'h0;
      tick_cnt_reg <= 12'h000;
      prev_reg     <= 1'b0;
      sc_cnt_reg   <= 8'h00;
      sc_reg       <= 1'b0;
      env_reg      <= 1'b0;
    end else begin
      state_reg    <= state_next;
      byte_reg     <= byte_next;
      slot_reg     <= slot_next;
      quarter_reg  <= quarter_next;
      tick_cnt_reg <= tick_cnt_next;
      prev_reg     <= prev_next;
      sc_cnt_reg   <= sc_cnt_next;
      sc_reg       <= sc_next;
      env_reg      <= env_next;
    end
  end

  assign tx_envelope_o = env_reg;
  assign tx_active_o   = (state_reg == ST_SEND);

  // checks
  logic plain;
  assign plain = (ptype == 2'h0) && !miller && (env == ENV_DIRECT) && !inv;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_byte_end;
    byte_end;
  endsequence

  sequence s_gap_done;
    (state_reg == ST_GAP) && tick && (quarter_reg == 2'h3);
  endsequence

  property p_plain_code;
    (state_reg == ST_SEND && code == CODE_NONE && plain) |=> (tx_envelope_o == $past(pb));
  endproperty
  a_plain_code: assert property (p_plain_code) else $error("plain code output mismatch"); // [R1]

  property p_rz_slot;
    (state_reg == ST_SEND && code >= CODE_RZ1 && code <= CODE_RZ4 && plain
     && slot_reg[1:0] != code[1:0]) |=> !tx_envelope_o;
  endproperty
  a_rz_slot: assert property (p_rz_slot) else $error("rz pulse in wrong slot"); // [R2]

  property p_1of4_len;
    (state_reg == ST_SEND && code == CODE_1OF4) |-> slot_reg <= 9'h00F;
  endproperty
  a_1of4_len: assert property (p_1of4_len) else $error("1 of 4 slot overrun"); // [R3]

  property p_256_slot;
    (state_reg == ST_SEND && code == CODE_256 && plain && slot_reg[7:0] != byte_reg)
    |=> !tx_envelope_o;
  endproperty
  a_256_slot: assert property (p_256_slot) else $error("1 of 256 pulse misplaced"); // [R4]

  property p_256z_zero;
    (state_reg == ST_SEND && code == CODE_256Z && plain && byte_reg == 8'h00)
    |=> !tx_envelope_o;
  endproperty
  a_256z_zero: assert property (p_256z_zero) else $error("zero byte modulated"); // [R5]

  property p_256l_zero;
    (state_reg == ST_SEND && code == CODE_256L && plain && byte_reg == 8'h00
     && slot_reg == 9'h0FF) |=> tx_envelope_o;
  endproperty
  a_256l_zero: assert property (p_256l_zero) else $error("zero byte not in last slot"); // [R6]

  property p_pie_len;
    (state_reg == ST_SEND && code == CODE_PIE) |-> slot_reg <= 9'h017;
  endproperty
  a_pie_len: assert property (p_pie_len) else $error("pie slot overrun"); // [R7]

  property p_sc_rate;
    (sc_on && sc_cnt_reg == sc_half_m1) |=> (sc_reg != $past(sc_reg)) || !sc_on;
  endproperty
  a_sc_rate: assert property (p_sc_rate) else $error("subcarrier missed toggle"); // [R8]

  property p_sc_off;
    !sc_on |=> !sc_reg;
  endproperty
  a_sc_off: assert property (p_sc_off) else $error("subcarrier runs unused"); // [R9]

  property p_rate;
    (state_reg != ST_IDLE) |-> tick_cnt_reg < quarter_len(br);
  endproperty
  a_rate: assert property (p_rate) else $error("quarter counter overrun"); // [R10]

  property p_fstep;
    s_byte_end and fstep |=> (state_reg == ST_GAP) && !tx_active_o;
  endproperty
  a_fstep: assert property (p_fstep) else $error("no frame gap after byte"); // [R11]

  property p_restart;
    s_gap_done and fifo_rd_valid |=> tx_active_o && slot_reg == 9'h000;
  endproperty
  a_restart: assert property (p_restart) else $error("no automatic restart"); // [R12]

  property p_stream;
    s_byte_end and !fstep and fifo_rd_valid |=> tx_active_o ##0 slot_reg == 9'h000;
  endproperty
  a_stream: assert property (p_stream) else $error("stream broke between bytes"); // [R13]

  property p_miller;
    (state_reg == ST_SEND && miller && !pb && prev_reg && env == ENV_DIRECT && !inv)
    |=> !tx_envelope_o;
  endproperty
  a_miller: assert property (p_miller) else $error("miller zero after one pulsed"); // [R14]

  property p_pulse_start;
    (state_reg == ST_SEND && !miller && ptype == 2'h1 && quarter_reg != 2'h0
     && env == ENV_DIRECT && !inv) |=> !tx_envelope_o;
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("pulse outside first quarter"); // [R15]

  property p_invert;
    (state_reg == ST_SEND && inv) |=> (tx_envelope_o == !$past(shaped));
  endproperty
  a_invert: assert property (p_invert) else $error("envelope not inverted"); // [R16]

  property p_manch;
    (state_reg == ST_SEND && env == ENV_MANCH && !inv && quarter_reg[1])
    |=> (tx_envelope_o == !$past(mod_level));
  endproperty
  a_manch: assert property (p_manch) else $error("manchester second half wrong"); // [R17]

  property p_rz_env;
    (state_reg == ST_SEND && !inv && ((env == ENV_RZ1ST && quarter_reg[1])
     || (env == ENV_RZ2ND && !quarter_reg[1]))) |=> !tx_envelope_o;
  endproperty
  a_rz_env: assert property (p_rz_env) else $error("rz envelope in wrong half"); // [R18]

endmodule // tdec_encoder

// [bench/tdec_rf_sink.sv]
// rf transmitter stand-in: counts frames, active cycles and envelope-high cycles
// assumes the encoder's single clock; clr_i wipes the counts between runs
`timescale 1ns/100ps
module tdec_rf_sink (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        clr_i,
  input  wire logic        env_i,
  input  wire logic        act_i,
  output logic      [31:0] frames_o,
  output logic      [31:0] act_cyc_o,
  output logic      [31:0] env_cyc_o
);
  logic act_q;
  // a receiver only listens, so it cannot be kinder than the real front end
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      act_q     <= 1'b0;
      frames_o  <= '0;
      act_cyc_o <= '0;
      env_cyc_o <= '0;
    end else begin
      act_q <= act_i;
      if (act_i && !act_q) frames_o <= frames_o + 32'h1;
      if (act_i) act_cyc_o <= act_cyc_o + 32'h1;
      if (env_i) env_cyc_o <= env_cyc_o + 32'h1;
    end
  end
endmodule // tdec_rf_sink

// [bench/tb_tx_data_encoder_config.sv]
// self-checking bench: wishbone register access and envelope counting
// assumes tdec_encoder and tdec_rf_sink; every run uses 848k, subcarrier envelopes are not counted
`timescale 1ns/100ps
module tb_tx_data_encoder_config;
  import tdec_pkg::*;
  localparam int BITC = 4 * Q_848K;
  localparam logic [9:0] A_COD = {IDX_CODING, 2'b00};
  localparam logic [9:0] A_MOD = {IDX_MOD, 2'b00};
  localparam logic [9:0] A_DAT = {IDX_DATA, 2'b00};
  localparam logic [9:0] A_CTL = {IDX_CTRL, 2'b00};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [9:0]  wb_adr_i = '0;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = '0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        tx_envelope_o;
  logic        tx_active_o;
  logic        clr = 1'b0;
  logic [31:0] frames, act_cyc, env_cyc, q, d;
  int          n_mismatch = 0;
  int          check_count = 0;

  always #5 clk_i = ~clk_i;

  tdec_encoder tdec_encoder_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tx_envelope_o(tx_envelope_o), .tx_active_o(tx_active_o));
  tdec_rf_sink tdec_rf_sink_inst (.clk_i(clk_i), .rst_i(rst_i), .clr_i(clr),
    .env_i(tx_envelope_o), .act_i(tx_active_o), .frames_o(frames), .act_cyc_o(act_cyc),
    .env_cyc_o(env_cyc));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one classic cycle; released only after the edge that sees ack
  task automatic wb(input logic we, input logic [9:0] a, input logic [31:0] v,
                    output logic [31:0] r);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= v;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 100);
    if (n >= 100) begin
      n_mismatch++;
      complete_run();
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // slots of one byte and quarters with the envelope high, for the shapes the bench uses
  function automatic void exp_q(input logic [7:0] cd, input logic [7:0] md,
                                input logic [7:0] b, output int s, output int hq);
    int   h;
    logic p;
    h = $countones(b);
    p = 1'b0;
    case (cd[7:4])
      4'h4, 4'h5, 4'h6, 4'h7: s = 32;
      4'h8: begin
        s = 16;
        h = 4;
      end
      4'h9, 4'hB: begin
        s = 256;
        h = 1;
      end
      4'hA: begin
        s = 256;
        h = int'(b != 8'h00);
      end
      4'hC: begin
        s = 16 + h;
        h = 8 + h;
      end
      default: s = 8;
    endcase
    if (md[2:0] == ENV_MANCH) hq = 2 * s;
    else if (md[2:0] != ENV_DIRECT) hq = 2 * h;
    else if (md[MILLER_BIT]) begin
      // miller on code 0 only: a zero after a one stays quiet
      hq = 0;
      for (int i = 0; i < 8; i++) begin
        hq += (b[i] || !p) ? 1 : 0;
        p = b[i];
      end
    end else hq = (md[5:4] == 2'h0) ? 4 * h : ((md[5:4] == 2'h2) ? 2 * h : h);
    if (md[INV_BIT]) hq = 4 * s - hq;
  endfunction

  // envelope high time follows the pulses of the chosen code and shape
  task automatic frame_run(input logic [7:0] md, input logic [7:0] cd, input int n);
    logic [7:0] b;
    int sq, hq, s, h, k;
    sq = 0;
    hq = 0;
    wb(1'b1, A_MOD, {24'h0, md}, q);
    wb(1'b1, A_COD, {24'h0, cd}, q);
    clr <= 1'b1;
    for (int i = 0; i < n; i++) begin
      b = (i == 0) ? 8'(cd[7:4] != CODE_256L) : 8'($urandom);
      exp_q(cd, md, b, s, h);
      sq += s;
      hq += h;
      wb(1'b1, A_DAT, {24'h0, b}, q);
    end
    clr <= 1'b0;
    if (n == FIFO_DEPTH) begin
      wb(1'b0, A_CTL, '0, q);
      chk("fifo_full_status", 32'h104, q);
    end
    wb(1'b1, A_CTL, 32'h1, q);
    k = 0;
    do begin
      wb(1'b0, A_CTL, '0, q);
      k++;
    end while (q[0] !== 1'b0 && k < 20000);
    if (k >= 20000) begin
      n_mismatch++;
      complete_run();
    end
    chk("idle_status", 32'h2, q);
    repeat (4) @(posedge clk_i);
    chk("frames", md[FSTEP_BIT] ? n : 1, frames);
    chk("active_cycles", sq * BITC, act_cyc);
    if (md[2:0] != ENV_MANSC && md[2:0] != ENV_BPSK) begin
      chk("env_cycles", hq * Q_848K, env_cyc);
    end
  endtask

  initial begin
    void'($urandom(59335));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, A_COD, '0, q);
    chk("coding_reset", {24'h0, CODING_RST}, q);
    wb(1'b0, A_MOD, '0, q);
    chk("mod_reset", {24'h0, MOD_RST}, q);
    d = $urandom;
    wb(1'b1, A_COD, d, q);
    wb(1'b0, A_COD, '0, q);
    chk("coding_rw", {24'h0, d[7:0]}, q);
    wb(1'b1, A_MOD, ~d, q);
    wb_sel_i <= 4'hE;
    wb(1'b1, A_MOD, d, q);
    wb_sel_i <= 4'hF;
    wb(1'b0, A_MOD, '0, q);
    chk("mod_rw", {24'h0, ~d[7:0]}, q);
    wb(1'b0, 10'h3FC, '0, q);
    chk("unmapped", 32'h0, q);
    frame_run(8'h00, 8'h07, 1);
    frame_run(8'h00, 8'h0F, 2);
    frame_run(8'h08, 8'h07, 1);
    frame_run(8'h80, 8'h07, 3);
    frame_run(8'h88, 8'h0F, FIFO_DEPTH);
    frame_run(8'h00, 8'h67, 2);
    frame_run(8'h10, 8'h87, 2);
    frame_run(8'h00, 8'hB7, 1);
    frame_run(8'h05, 8'hC7, 2);
    frame_run(8'h50, 8'h07, 1);
    frame_run(8'h01, 8'h07, 1);
    frame_run(8'h03, 8'h0F, 1);
    complete_run();
  end
endmodule // tb_tx_data_encoder_config
